/* File: core/capture_compare_unit.v */
// Capture/compare/PWM unit with its period timer, behind a classic Wishbone slave.
// Assumes the 16-bit wide timer count comes in synchronous to CLOCK_I and that the
// pin direction and port data are kept outside; the pin level is always watched.
`timescale 1ns/100ps
`include "capture_compare_regs.vh"

// Function
// - Value low/high and control software read/write
// - Mode 0000 disables and resets unit
// - Capture edge per mode 0100-0111
// - Compare 1000 sets, 1001 clears output
// - Compare 1010 only sets flag
// - Compare 1011 flags and emits special trigger
// - PWM on 11xx, duty from value low
// - Capture/compare use wide timer, PWM period
// - Capture copies wide timer into value
// - Capture sets sticky flag, software clears
// - New capture overwrites silently
// - Pin level watched even as output
// - Control bits 7-6 read zero
// - Postscaler 1:1 to 1:16 before flag
// - On bit starts and stops timer
// - Capture prescaler cleared when not capturing
module capture_compare_unit (
  input  wire        CLOCK_I,          // System clock, 200 MHz
  input  wire        SRST_I,           // Synchronous reset, active high
  input  wire        WB_CYC_I,         // Wishbone cycle
  input  wire        WB_STB_I,         // Wishbone strobe
  input  wire        WB_WE_I,          // Wishbone write enable
  input  wire [9:0]  WB_ADR_I,         // Wishbone byte address
  input  wire [3:0]  WB_SEL_I,         // Wishbone byte selects
  input  wire [31:0] WB_DAT_I,         // Wishbone write data
  output reg  [31:0] WB_DAT_O,         // Wishbone read data
  output reg         WB_ACK_O,         // Wishbone acknowledge
  input  wire [15:0] WIDE_COUNT_I,     // Wide timer count
  input  wire        PIN_I,            // Capture/compare pin level
  output reg         PIN_O,            // Compare/PWM output latch
  output reg         SPECIAL_TRIG_O,   // Special event trigger pulse
  output reg         PERIOD_MATCH_O    // Period timer match pulse, before postscale
);

  reg  [7:0] core_interrupt_control;
  reg  [7:0] peripheral_irq_flags;
  reg  [7:0] peripheral_irq_enables;
  reg  [6:0] period_timer_control;
  reg  [7:0] period_timer_limit;
  reg  [5:0] unit_control;
  reg  [7:0] unit_value_low;
  reg  [7:0] unit_value_high;
  reg  [3:0] cap_prescale;
  reg  [9:0] duty_latched;
  reg  [1:0] pwm_fine;
  reg  [7:0] next_rdata;
  reg        capture_event;
  reg        cmp_match_d;

  wire [3:0] unit_mode_field = unit_control[3:0];
  wire       is_capture      = (unit_mode_field[3:2] == 2'b01);
  wire       is_compare      = (unit_mode_field[3:2] == 2'b10);
  wire       is_pwm          = (unit_mode_field[3:2] == 2'b11);

  wire [7:0] reg_index = WB_ADR_I[9:2];
  wire       bus_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire       bus_wr    = bus_req & WB_WE_I & WB_SEL_I[0];
  wire [7:0] wdata     = WB_DAT_I[7:0];

  wire wr_irq_flags    = bus_wr && (reg_index == `IDX_IRQ_FLAGS);
  wire wr_period_count = bus_wr && (reg_index == `IDX_PERIOD_COUNT);
  wire wr_period_ctrl  = bus_wr && (reg_index == `IDX_PERIOD_CTRL);
  wire wr_value_low    = bus_wr && (reg_index == `IDX_VALUE_LOW);
  wire wr_value_high   = bus_wr && (reg_index == `IDX_VALUE_HIGH);
  wire wr_unit_ctrl    = bus_wr && (reg_index == `IDX_UNIT_CTRL);

  wire       pin_rise;
  wire       pin_fall;
  wire [7:0] period_timer_count;
  wire       period_match;
  wire       period_post;

  capture_edge_detect edges (
    .clk_i  (CLOCK_I),
    .rst_i  (SRST_I),
    .pin_i  (PIN_I),
    .rise_o (pin_rise),
    .fall_o (pin_fall)
  );

  period_timer ptimer (
    .clk_i         (CLOCK_I),
    .rst_i         (SRST_I),
    .ctrl_i        (period_timer_control),
    .ctrl_wr_i     (wr_period_ctrl),
    .limit_i       (period_timer_limit),
    .count_wr_i    (wr_period_count),
    .count_wdata_i (wdata),
    .count_o       (period_timer_count),
    .match_o       (period_match),
    .post_o        (period_post)
  );

  // Capture event selection
  always @* begin
    case (unit_mode_field)
      `MODE_CAP_FALL:   capture_event = pin_fall;
      `MODE_CAP_RISE:   capture_event = pin_rise;
      `MODE_CAP_RISE4:  capture_event = pin_rise && (cap_prescale[1:0] == 2'b11);
      `MODE_CAP_RISE16: capture_event = pin_rise && (cap_prescale == 4'hF);
      default:          capture_event = 1'b0;
    endcase
  end

  // Compare against the wide timer; act once per match entry
  wire cmp_equal = is_compare && ({unit_value_high, unit_value_low} == WIDE_COUNT_I);
  wire cmp_match = cmp_equal && !cmp_match_d;

  always @(posedge CLOCK_I) begin
    if (SRST_I || !is_capture) begin
      cap_prescale <= 4'h0;
    end else if (pin_rise) begin
      cap_prescale <= cap_prescale + 4'h1;
    end
  end

  always @(posedge CLOCK_I) begin
    if (SRST_I)
      cmp_match_d <= 1'b0;
    else
      cmp_match_d <= cmp_equal;
  end

  // Unit control: bits 7-6 never stored
  always @(posedge CLOCK_I) begin
    if (SRST_I)
      unit_control <= 6'h00;
    else if (wr_unit_ctrl)
      unit_control <= wdata[5:0];
  end

  // Value registers: software writes, capture overwrites
  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      unit_value_low  <= `RST_BYTE_ZERO;
      unit_value_high <= `RST_BYTE_ZERO;
    end else if (capture_event) begin
      unit_value_low  <= WIDE_COUNT_I[7:0];
      unit_value_high <= WIDE_COUNT_I[15:8];
    end else begin
      if (wr_value_low)
        unit_value_low <= wdata;
      if (wr_value_high)
        unit_value_high <= wdata;
    end
  end

  // Flags: hardware set wins over a software clear in the same cycle
  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      peripheral_irq_flags <= `RST_BYTE_ZERO;
    end else begin
      if (wr_irq_flags)
        peripheral_irq_flags <= wdata & `MASK_IRQ_IMPL;
      if (capture_event || cmp_match)
        peripheral_irq_flags[`BIT_UNIT_IRQ] <= 1'b1;
      if (period_post)
        peripheral_irq_flags[`BIT_PERIOD_IRQ] <= 1'b1;
    end
  end

  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      core_interrupt_control <= `RST_BYTE_ZERO;
      peripheral_irq_enables <= `RST_BYTE_ZERO;
      period_timer_control   <= 7'h00;
      period_timer_limit     <= `RST_PERIOD_LIMIT;
    end else if (bus_wr) begin
      case (reg_index)
        `IDX_CORE_INT_CTRL: core_interrupt_control <= wdata;
        `IDX_IRQ_ENABLES:   peripheral_irq_enables <= wdata & `MASK_IRQ_IMPL;
        `IDX_PERIOD_CTRL:   period_timer_control   <= wdata[6:0];
        `IDX_PERIOD_LIMIT:  period_timer_limit     <= wdata;
        default:            ;
      endcase
    end
  end

  // PWM: 10-bit duty latched at period start, two fine bits stretch the count
  wire [9:0] pwm_pos = {period_timer_count, pwm_fine};
  always @(posedge CLOCK_I) begin
    if (SRST_I || !is_pwm) begin
      duty_latched <= 10'h000;
      pwm_fine     <= 2'b00;
    end else begin
      pwm_fine <= pwm_fine + 2'b01;
      if (period_match)
        duty_latched <= {unit_value_low, unit_control[5:4]};
    end
  end

  // Output latch and special trigger
  always @(posedge CLOCK_I) begin
    SPECIAL_TRIG_O <= 1'b0;
    // Period timer is not part of the unit, so its match ignores the mode
    PERIOD_MATCH_O <= period_match & ~SRST_I;
    if (SRST_I || unit_mode_field == `MODE_OFF) begin
      PIN_O <= 1'b0;
    end else begin
      if (is_pwm) begin
        if (period_match)
          PIN_O <= ({unit_value_low, unit_control[5:4]} != 10'h000);
        else if (pwm_pos >= duty_latched)
          PIN_O <= 1'b0;
      end else if (cmp_match) begin
        case (unit_mode_field)
          `MODE_CMP_SET:     PIN_O <= 1'b1;
          `MODE_CMP_CLEAR:   PIN_O <= 1'b0;
          `MODE_CMP_SOFT:    PIN_O <= PIN_O;
          `MODE_CMP_SPECIAL: SPECIAL_TRIG_O <= 1'b1;
          default:           PIN_O <= PIN_O;
        endcase
      end
    end
  end

  // Read mux
  always @* begin
    case (reg_index)
      `IDX_CORE_INT_CTRL: next_rdata = core_interrupt_control;
      `IDX_IRQ_FLAGS:     next_rdata = peripheral_irq_flags;
      `IDX_PERIOD_COUNT:  next_rdata = period_timer_count;
      `IDX_PERIOD_CTRL:   next_rdata = {1'b0, period_timer_control};
      `IDX_VALUE_LOW:     next_rdata = unit_value_low;
      `IDX_VALUE_HIGH:    next_rdata = unit_value_high;
      `IDX_UNIT_CTRL:     next_rdata = {2'b00, unit_control};
      `IDX_IRQ_ENABLES:   next_rdata = peripheral_irq_enables;
      `IDX_PERIOD_LIMIT:  next_rdata = period_timer_limit;
      default:            next_rdata = 8'h00;
    endcase
  end

  // One-cycle answer; unmapped reads return zero, writes are dropped
  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= bus_req;
      if (bus_req && !WB_WE_I)
        WB_DAT_O <= {24'h00_0000, next_rdata};
    end
  end

endmodule // capture_compare_unit

/* File: common/capture_compare_regs.vh */
// Register offsets, field positions, reset values and timing counts for the capture/compare unit.
// Assumes a byte-wide register map reached by word index over a Wishbone slave.
`ifndef CAPTURE_COMPARE_REGS_VH
`define CAPTURE_COMPARE_REGS_VH

// Register indices; byte address is four times the index
`define IDX_CORE_INT_CTRL    8'h0B
`define IDX_IRQ_FLAGS        8'h0C
`define IDX_PERIOD_COUNT     8'h11
`define IDX_PERIOD_CTRL      8'h12
`define IDX_VALUE_LOW        8'h15
`define IDX_VALUE_HIGH       8'h16
`define IDX_UNIT_CTRL        8'h17
`define IDX_IRQ_ENABLES      8'h8C
`define IDX_PERIOD_LIMIT     8'h92

// Reset values
`define RST_BYTE_ZERO        8'h00
`define RST_PERIOD_LIMIT     8'hFF

// Flag and enable bit positions in the peripheral flag/enable registers
`define BIT_PERIOD_IRQ       1
`define BIT_UNIT_IRQ         2
`define MASK_IRQ_IMPL        8'h47

// Period timer control fields
`define BIT_PERIOD_ON        2
`define MASK_PERIOD_CTRL     8'h7F

// Unit control fields
`define MASK_UNIT_CTRL       8'h3F

// Mode encodings
`define MODE_OFF             4'h0
`define MODE_CAP_FALL        4'h4
`define MODE_CAP_RISE        4'h5
`define MODE_CAP_RISE4       4'h6
`define MODE_CAP_RISE16      4'h7
`define MODE_CMP_SET         4'h8
`define MODE_CMP_CLEAR       4'h9
`define MODE_CMP_SOFT        4'hA
`define MODE_CMP_SPECIAL     4'hB

// Timing: the period timer input runs at one quarter of the system clock
`define PERIOD_BASE_DIV      2'd3
`define PRESCALE_4_LAST      4'd3
`define PRESCALE_16_LAST     4'd15

`endif

/* File: core/capture_edge_detect.v */
// Capture pin synchroniser and edge detector.
// Assumes the pin may change at any time relative to CLOCK_I.
`timescale 1ns/100ps
module capture_edge_detect (
  input  wire clk_i,    // System clock
  input  wire rst_i,    // Synchronous reset
  input  wire pin_i,    // Raw pin level
  output reg  rise_o,   // One-cycle rising-edge pulse
  output reg  fall_o    // One-cycle falling-edge pulse
);

  reg sync_a;
  reg sync_b;
  reg prev;

  // First stage feeds only the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
      prev   <= sync_b;
      rise_o <= sync_b & ~prev;
      fall_o <= ~sync_b & prev;
    end
  end

endmodule // capture_edge_detect

/* File: core/period_timer.v */
// 8-bit period timer with prescaler, limit match and postscaler.
// Assumes write strobes arrive as single-cycle pulses from the register decode.
`timescale 1ns/100ps
`include "capture_compare_regs.vh"
module period_timer (
  input  wire       clk_i,          // System clock
  input  wire       rst_i,          // Synchronous reset
  input  wire [6:0] ctrl_i,         // Period timer control bits 6-0
  input  wire       ctrl_wr_i,      // Control written this cycle
  input  wire [7:0] limit_i,        // Period limit
  input  wire       count_wr_i,     // Count written this cycle
  input  wire [7:0] count_wdata_i,  // Count write data
  output reg  [7:0] count_o,        // Current count
  output reg        match_o,        // Pulse on rollover at limit
  output reg        post_o          // Pulse after postscale
);

  reg  [1:0] base_div;
  reg  [3:0] pre_cnt;
  reg  [3:0] post_cnt;
  reg  [3:0] pre_last;
  wire       base_tick = (base_div == `PERIOD_BASE_DIV);
  wire       running   = ctrl_i[`BIT_PERIOD_ON];

  always @* begin
    case (ctrl_i[1:0])
      2'b00:   pre_last = 4'h0;
      2'b01:   pre_last = `PRESCALE_4_LAST;
      default: pre_last = `PRESCALE_16_LAST;
    endcase
  end

  always @(posedge clk_i) begin
    match_o <= 1'b0;
    post_o  <= 1'b0;
    if (rst_i) begin
      base_div <= 2'd0;
      pre_cnt  <= 4'h0;
      post_cnt <= 4'h0;
      count_o  <= `RST_BYTE_ZERO;
    end else if (count_wr_i || ctrl_wr_i) begin
      // Writes clear both scalers; a control write leaves the count alone
      pre_cnt  <= 4'h0;
      post_cnt <= 4'h0;
      if (count_wr_i)
        count_o <= count_wdata_i;
    end else if (running) begin
      base_div <= base_div + 2'd1;
      if (base_tick) begin
        if (pre_cnt >= pre_last) begin
          pre_cnt <= 4'h0;
          if (count_o == limit_i) begin
            count_o <= 8'h00;
            match_o <= 1'b1;
            if (post_cnt == ctrl_i[6:3]) begin
              post_cnt <= 4'h0;
              post_o   <= 1'b1;
            end else begin
              post_cnt <= post_cnt + 4'h1;
            end
          end else begin
            count_o <= count_o + 8'h01;
          end
        end else begin
          pre_cnt <= pre_cnt + 4'h1;
        end
      end
    end
  end

endmodule // period_timer

/* File: tb/capture_pin_source.sv */
// Pin source model: drives the capture pin with bursts of whole pulses.
// Assumes a burst request is one clock wide and arrives while idle.
`timescale 1ns/100ps
module capture_pin_source #(
  parameter HALF = 4           // Cycles per pin level
) (
  input  wire       clk_i,     // Clock
  input  wire       start_i,   // Begin a burst
  input  wire [4:0] pulses_i,  // Pulses in the burst
  output reg        pin_o,     // Pin level, idle low
  output reg        busy_o     // Burst running
);
  reg [4:0] left = 5'h00;
  reg [3:0] ph   = 4'h0;
  initial pin_o = 1'b0;
  initial busy_o = 1'b0;
  // Slow edges so every one survives the two-flop synchroniser
  always @(posedge clk_i) begin
    if (start_i && !busy_o) begin
      left   <= pulses_i;
      busy_o <= pulses_i != 5'h00;
      ph     <= 4'h0;
    end else if (busy_o) begin
      ph <= (ph == HALF - 1) ? 4'h0 : ph + 4'h1;
      if (ph == HALF - 1) begin
        pin_o <= ~pin_o;
        if (pin_o) left <= left - 5'h01;
        if (pin_o && left == 5'h01) busy_o <= 1'b0;
      end
    end
  end
endmodule // capture_pin_source

/* File: tb/capture_compare_unit_assertions.sv */
// Port checker for the capture/compare unit.
// Assumes it is bound to the unit and sees its ports only.
`timescale 1ns/100ps
module capture_compare_unit_assertions (
  input wire        CLOCK_I,         // Clock
  input wire        SRST_I,          // Reset
  input wire        WB_CYC_I,        // Cycle
  input wire        WB_STB_I,        // Strobe
  input wire        WB_WE_I,         // Write
  input wire [9:0]  WB_ADR_I,        // Address
  input wire [3:0]  WB_SEL_I,        // Selects
  input wire [31:0] WB_DAT_I,        // Write data
  input wire [31:0] WB_DAT_O,        // Read data
  input wire        WB_ACK_O,        // Ack
  input wire [15:0] WIDE_COUNT_I,    // Wide count
  input wire        PIN_I,           // Pin
  input wire        PIN_O,           // Output latch
  input wire        SPECIAL_TRIG_O,  // Trigger
  input wire        PERIOD_MATCH_O   // Period match
);
  reg  [3:0] mode;
  reg        t_on;
  reg  [1:0] age;
  wire       wr  = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0];
  wire       hit = WB_ADR_I[9:2] == 8'h17;
  // Mode is only trusted a few cycles after a write, while old matches drain
  wire       settled = age == 2'h3;
  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      mode <= 4'h0;
      t_on <= 1'b0;
      age  <= 2'h0;
    end else begin
      age <= (wr && hit) ? 2'h0 : settled ? age : age + 2'h1;
      if (wr && hit) mode <= WB_DAT_I[3:0];
      if (wr && WB_ADR_I[9:2] == 8'h12) t_on <= WB_DAT_I[2];
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  chk_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
  chk_ack_one: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  chk_ctrl_msbs: assert property (WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O && hit
    |=> WB_DAT_O[7:6] == 2'b00) else $error("control top bits set");
  chk_reset_quiet: assert property (disable iff (1'b0) SRST_I
    |=> !WB_ACK_O && !PIN_O && !SPECIAL_TRIG_O && !PERIOD_MATCH_O) else $error("output live in reset");
  chk_off_low: assert property (settled && mode == 4'h0 |-> !PIN_O) else $error("pin high when off");
  chk_set_hold: assert property (settled && mode == 4'h8 |-> !$fell(PIN_O)) else $error("pin fell in set mode");
  chk_clear_hold: assert property (settled && mode == 4'h9 |-> !$rose(PIN_O)) else $error("pin rose");
  chk_soft_pin: assert property (settled && mode == 4'hA |-> $stable(PIN_O)) else $error("pin moved");
  chk_trig_mode: assert property (settled && mode != 4'hB |-> !SPECIAL_TRIG_O) else $error("stray trigger");
  chk_timer_off: assert property (!t_on [*3] |-> !PERIOD_MATCH_O) else $error("match while off");
  cover property (SPECIAL_TRIG_O);
  cover property (PERIOD_MATCH_O);
  cover property (WB_ACK_O && !WB_WE_I);
endmodule // capture_compare_unit_assertions
bind capture_compare_unit capture_compare_unit_assertions i_chk (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WIDE_COUNT_I(WIDE_COUNT_I),
  .PIN_I(PIN_I), .PIN_O(PIN_O), .SPECIAL_TRIG_O(SPECIAL_TRIG_O), .PERIOD_MATCH_O(PERIOD_MATCH_O));

/* File: tb/tb.sv */
// Self-checking bench for the capture/compare unit.
// Assumes the pin source model and the bound checker are compiled first.
`timescale 1ns/100ps
module tb;
  reg         clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, start = 0, p;
  reg  [9:0]  adr = 10'h000;
  reg  [31:0] wdat = 32'h0000_0000;
  reg  [15:0] wide = 16'h0000, v;
  reg  [4:0]  pulses = 5'h00;
  reg  [7:0]  q;
  wire [31:0] rdat;
  wire        ack, pin, pin_out, trig, pmatch, busy;
  integer     err_total = 0, comparisons = 0, seed = 2, cycles = 0, i, n, trig_cnt = 0, t0;
  // Ten register indices packed first to last; the last one is unmapped
  localparam [79:0] IDX = 80'h0B0C_1112_1516_178C_9220;
  always #2.5 clk = ~clk;
  capture_compare_unit i_capture_compare_unit (.CLOCK_I(clk), .SRST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .WIDE_COUNT_I(wide), .PIN_I(pin), .PIN_O(pin_out), .SPECIAL_TRIG_O(trig), .PERIOD_MATCH_O(pmatch));
  capture_pin_source i_capture_pin_source (.clk_i(clk), .start_i(start), .pulses_i(pulses), .pin_o(pin),
    .busy_o(busy));
  function [7:0] rst_val(input [7:0] idx);
    rst_val = (idx == 8'h92) ? 8'hFF : 8'h00;
  endfunction
  function [4:0] pre_pulses(input integer m);
    pre_pulses = (m == 6) ? 5'd3 : (m == 7) ? 5'd15 : 5'd1;
  endfunction
  function [15:0] period_exp(input integer ps);
    period_exp = 12 * ((ps == 0) ? 1 : (ps == 1) ? 4 : 16);
  endfunction
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (trig === 1'b1) trig_cnt <= trig_cnt + 1;
    // Generous ceiling; the full run needs about two thousand cycles
    if (cycles == 60000) begin
      err_total = err_total + 1;
      end_of_test;
    end
  end
  task check(input string name, input [15:0] seen, input [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("ERROR %0s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wb(input w, input [7:0] idx, input [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    n = 0;
    do begin @(posedge clk); n = n + 1; end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20) err_total = err_total + 1;
  endtask
  task rd(input [7:0] idx, input [7:0] exp, input string name);
    wb(1'b0, idx, 8'h00);
    check(name, q, exp);
  endtask
  task pulse(input [4:0] k);
    @(posedge clk);
    pulses <= k;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    @(posedge clk);
    while (busy === 1'b1 && n < 400) begin @(posedge clk); n = n + 1; end
    repeat (6) @(posedge clk);
  endtask
  task wait_match;
    n = 0;
    do begin @(posedge clk); n = n + 1; end while (pmatch !== 1'b1 && n < 1000);
    if (n == 1000) err_total = err_total + 1;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wb(1'b1, 8'h20, 8'h5A);
    for (i = 0; i < 10; i++) rd(IDX[8*(9-i) +: 8], rst_val(IDX[8*(9-i) +: 8]), "reset value");
    $display("reset test done");
    v = $random(seed);
    wb(1'b1, 8'h15, v[7:0]);
    wb(1'b1, 8'h16, v[15:8]);
    wb(1'b1, 8'h17, 8'hFF);
    rd(8'h15, v[7:0], "value low");
    rd(8'h16, v[15:8], "value high");
    rd(8'h17, 8'h3F, "unit control");
    wb(1'b1, 8'h17, 8'h00);
    repeat (3) @(posedge clk);
    check("pin when off", pin_out, 16'h0000);
    $display("register test done");
    for (i = 4; i < 8; i++) begin
      wb(1'b1, 8'h17, 8'h00);
      wb(1'b1, 8'h17, i);
      wb(1'b1, 8'h0C, 8'h00);
      @(posedge clk) wide <= $random(seed);
      pulse(pre_pulses(i));
      rd(8'h0C, (i < 6) ? 8'h04 : 8'h00, "early flag");
      v = $random(seed);
      @(posedge clk) wide <= v;
      pulse(5'd1);
      rd(8'h15, v[7:0], "capture low");
      rd(8'h16, v[15:8], "capture high");
      rd(8'h0C, 8'h04, "capture flag");
      wb(1'b1, 8'h0C, 8'h00);
      rd(8'h0C, 8'h00, "flag cleared");
    end
    $display("capture test done");
    for (i = 8; i < 12; i++) begin
      v = $random(seed);
      @(posedge clk) wide <= v + 16'h0001;
      wb(1'b1, 8'h15, v[7:0]);
      wb(1'b1, 8'h16, v[15:8]);
      wb(1'b1, 8'h17, i);
      wb(1'b1, 8'h0C, 8'h00);
      t0 = trig_cnt;
      p = pin_out;
      @(posedge clk) wide <= v;
      repeat (4) @(posedge clk);
      if (i < 11) check("compare pin", pin_out, (i == 8) ? 1'b1 : (i == 9) ? 1'b0 : p);
      check("trigger", trig_cnt - t0, i == 11);
      rd(8'h0C, 8'h04, "compare flag");
    end
    $display("compare test done");
    wb(1'b1, 8'h92, 8'h02);
    for (i = 0; i < 4; i++) begin
      wb(1'b1, 8'h12, 8'h04 | i);
      wait_match;
      wait_match;
      check("period", n, period_exp(i));
    end
    wb(1'b1, 8'h12, 8'h00);
    wb(1'b1, 8'h0C, 8'h00);
    wb(1'b1, 8'h12, 8'h1C);
    repeat (3) wait_match;
    rd(8'h0C, 8'h00, "postscale early");
    wait_match;
    repeat (3) @(posedge clk);
    rd(8'h0C, 8'h02, "postscale flag");
    wb(1'b1, 8'h12, 8'h00);
    wb(1'b1, 8'h11, 8'h01);
    repeat (30) @(posedge clk);
    rd(8'h11, 8'h01, "stopped count");
    $display("period timer test done");
    // Full duty outlasts every period position; zero duty never sets the pin
    wb(1'b1, 8'h15, 8'hFF);
    wb(1'b1, 8'h17, 8'h0C);
    wb(1'b1, 8'h12, 8'h04);
    repeat (2) wait_match;
    repeat (2) @(posedge clk);
    check("pwm full", pin_out, 16'h0001);
    wb(1'b1, 8'h15, 8'h00);
    repeat (2) wait_match;
    repeat (2) @(posedge clk);
    check("pwm zero", pin_out, 16'h0000);
    $display("pwm test done");
    end_of_test;
  end
endmodule // tb
